/* hw/periodic_timer.sv */
// Periodic timer with compare A and period comparators, APB registers.
// Assumes tick_en is a one-cycle timer clock enable made elsewhere and
// that both pin inputs are already synchronous to pclk.
`timescale 1ns/1ns
module periodic_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire timer_pkg::apb_req_t apb_req,
  output timer_pkg::apb_rsp_t apb_rsp,
  // Timer clock enable
  input wire logic tick_en,
  // Pins
  input wire timer_pkg::pin_in_t pins_in,
  output timer_pkg::pin_out_t pins_out
);
  import timer_pkg::*;

  tmr_state_t s_r;
  tmr_state_t s_nxt;
  logic wr_en;
  logic setup;
  mode_t mode;
  logic [1:0] fn;
  logic [16:0] inc;
  logic [15:0] peff;
  logic sp_mode;
  logic run_go;
  logic a_hit;
  logic p_hit;
  logic clr_hit;
  logic a_evt;
  logic p_evt;
  logic ext_rise;
  logic cap_old;
  logic cap_now;
  logic cap_evt;
  logic run_rise;
  logic pwm_act;
  logic [1:0] flg_clr;
  logic [1:0] flg_set;

  // Zero period stands for the longest period
  function automatic logic [15:0] period_eff(input logic [15:0] per);
    period_eff = (per == 16'h0000) ? CNT_MAX : per;
  endfunction

  function automatic logic edge_hit(input logic [1:0] f,
                                    input logic old,
                                    input logic now);
    logic rise;
    logic fall;
    rise = now & ~old;
    fall = ~now & old;
    unique case (f)
      FN_LOW: edge_hit = rise;
      FN_HIGH: edge_hit = fall;
      FN_BOTH: edge_hit = rise | fall;
      FN_TOGGLE: edge_hit = 1'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_RUN) || (a == OFS_CTL) || (a == OFS_CNT) ||
             (a == OFS_CA) || (a == OFS_PER_LO) || (a == OFS_PER_HI) ||
             (a == OFS_FLAGS);
  endfunction

  function automatic logic [31:0] read_word(input tmr_state_t st,
                                            input logic [7:0] a);
    read_word = 32'h0000_0000;
    if (a == OFS_RUN) begin
      read_word[RUN_BIT] = st.run;
    end
    if (a == OFS_CTL) begin
      read_word[7:0] = st.ctl;
    end
    if (a == OFS_CNT) begin
      read_word[15:0] = st.cnt;
    end
    if (a == OFS_CA) begin
      read_word[15:0] = st.ca;
    end
    if (a == OFS_PER_LO) begin
      read_word[7:0] = st.per[7:0];
    end
    if (a == OFS_PER_HI) begin
      read_word[7:0] = st.per[15:8];
    end
    if (a == OFS_FLAGS) begin
      read_word[1:0] = st.flg;
    end
  endfunction

  // Decode of the present configuration
  assign mode = mode_t'(s_r.ctl[CTL_MODE_LO +: 2]);
  assign fn = s_r.ctl[CTL_FN_LO +: 2];
  assign sp_mode = (mode == MODE_PWM) && (fn == FN_TOGGLE);
  assign peff = period_eff(s_r.per);
  assign inc = {1'h0, s_r.cnt} + 17'h00001;
  assign run_go = s_r.run & tick_en;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & s_r.rdy;

  // Pin edges; inputs are already synchronous
  assign ext_rise = pins_in.ext_clk & ~s_r.ext_q;
  assign cap_now = s_r.ctl[CTL_CSS] ? pins_in.ext_clk :
                   pins_in.cap_in;
  assign cap_old = s_r.ctl[CTL_CSS] ? s_r.ext_q : s_r.cap_q;
  assign cap_evt = (mode == MODE_CAPTURE) && s_r.run &&
                   edge_hit(fn, cap_old, cap_now);

  // Comparator outcomes per mode
  always_comb begin
    a_hit = 1'h0;
    p_hit = 1'h0;
    clr_hit = 1'h0;
    unique case (mode)
      MODE_COMPARE, MODE_TIMER: begin
        if (s_r.ctl[CTL_CLR]) begin
          a_hit = (s_r.ca != 16'h0000) && (inc[15:0] == s_r.ca);
          clr_hit = a_hit || ((s_r.ca == 16'h0000) &&
                              (s_r.cnt == CNT_MAX));
        end else begin
          a_hit = (s_r.ca != 16'h0000) && (inc[15:0] == s_r.ca);
          p_hit = (s_r.per != 16'h0000) ? (inc[15:0] == s_r.per) :
                  (s_r.cnt == CNT_MAX);
          clr_hit = p_hit;
        end
      end
      MODE_PWM: begin
        if (sp_mode) begin
          // Period value is not used; counter simply wraps
          a_hit = inc[15:0] == s_r.ca;
        end else begin
          a_hit = inc[15:0] == s_r.ca;
          p_hit = inc >= {1'h0, peff};
          clr_hit = p_hit;
        end
      end
      MODE_CAPTURE: begin
        p_hit = (s_r.per != 16'h0000) ? (inc[15:0] == s_r.per) :
                (s_r.cnt == CNT_MAX);
        clr_hit = p_hit;
      end
    endcase
  end

  assign a_evt = run_go & a_hit;
  assign p_evt = run_go & p_hit;

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_q = pins_in.ext_clk;
    s_nxt.cap_q = pins_in.cap_in;
    flg_clr = 2'h0;
    // Register writes
    if (wr_en) begin
      if (apb_req.paddr == OFS_RUN) begin
        s_nxt.run = apb_req.pwdata[RUN_BIT];
      end
      if (apb_req.paddr == OFS_CTL) begin
        s_nxt.ctl = apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == OFS_CA) begin
        s_nxt.ca = apb_req.pwdata[15:0];
      end
      if (apb_req.paddr == OFS_PER_LO) begin
        s_nxt.per[7:0] = apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == OFS_PER_HI) begin
        s_nxt.per[15:8] = apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == OFS_FLAGS) begin
        flg_clr = apb_req.pwdata[1:0];
      end
    end
    // Clock pin edge starts a single pulse
    if (sp_mode && !s_r.run && ext_rise) begin
      s_nxt.run = 1'h1;
    end
    // Compare A match ends the pulse; beats a software write
    if (sp_mode && a_evt) begin
      s_nxt.run = 1'h0;
    end
    run_rise = ~s_r.run & s_nxt.run;
    // Counter
    if (run_go) begin
      s_nxt.cnt = clr_hit ? 16'h0000 : inc[15:0];
    end
    if (run_rise) begin
      s_nxt.cnt = 16'h0000;
    end
    // Capture wins over a same-cycle write to compare A
    if (cap_evt) begin
      s_nxt.ca = s_r.cnt;
    end
    // Flags: a set in the clearing cycle is kept
    flg_set[FLG_A] = a_evt | cap_evt;
    flg_set[FLG_P] = p_evt;
    s_nxt.flg = (s_r.flg & ~flg_clr) | flg_set;
    // Compare mode level
    if (run_rise) begin
      s_nxt.lvl = s_r.ctl[CTL_OIL];
    end else if (a_evt && (mode == MODE_COMPARE)) begin
      unique case (fn)
        FN_LOW: s_nxt.lvl = s_r.lvl;
        FN_HIGH: s_nxt.lvl = 1'h0;
        FN_BOTH: s_nxt.lvl = 1'h1;
        FN_TOGGLE: s_nxt.lvl = ~s_r.lvl;
      endcase
    end
    // PWM and single pulse activity
    if (sp_mode) begin
      pwm_act = s_nxt.run;
    end else if (fn == FN_LOW) begin
      pwm_act = 1'h0;
    end else if (fn == FN_HIGH) begin
      pwm_act = 1'h1;
    end else begin
      pwm_act = (s_r.cnt < s_r.ca) || (s_r.ca >= peff);
    end
    // Pin drive; capture and timer modes leave it free
    unique case (mode)
      MODE_COMPARE: begin
        s_nxt.pin = s_nxt.lvl ^ s_r.ctl[CTL_INV];
        s_nxt.oe = 1'h1;
      end
      MODE_PWM: begin
        s_nxt.pin = ~(pwm_act ^ s_r.ctl[CTL_OIL]) ^
                    s_r.ctl[CTL_INV];
        s_nxt.oe = 1'h1;
      end
      MODE_CAPTURE, MODE_TIMER: begin
        s_nxt.pin = 1'h0;
        s_nxt.oe = 1'h0;
      end
    endcase
    // Bus answer one cycle after setup; unmapped gives an error
    s_nxt.rdy = setup;
    if (setup) begin
      s_nxt.err = ~mapped(apb_req.paddr);
      s_nxt.rdata = read_word(s_r, apb_req.paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp.pready = s_r.rdy;
  assign apb_rsp.pslverr = s_r.err;
  assign apb_rsp.prdata = s_r.rdata;
  assign pins_out.level = s_r.pin;
  assign pins_out.oe = s_r.oe;

  a_run_restart: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(s_r.run) |-> s_r.cnt == 16'h0000)
    else $error("counter not zero after run rise");

  a_stop_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!s_r.run && !$past(s_r.run)) |-> $stable(s_r.cnt))
    else $error("stopped counter moved");

  a_init_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_rise |=> s_r.lvl == $past(s_r.ctl[CTL_OIL]))
    else $error("pin level not initial after run rise");

  a_cmp_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (a_evt && mode == MODE_COMPARE && fn == FN_TOGGLE)
    |=> s_r.lvl != $past(s_r.lvl))
    else $error("toggle on compare A missing");

  a_cmp_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && mode == MODE_COMPARE && !s_r.ctl[CTL_CLR] &&
     s_r.per != 16'h0000 && inc[15:0] == s_r.per)
    |=> s_r.cnt == 16'h0000 && s_r.flg[FLG_P])
    else $error("period match did not clear and flag");

  a_no_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((mode == MODE_COMPARE || mode == MODE_TIMER) && s_r.ctl[CTL_CLR])
    |=> !$rose(s_r.flg[FLG_P]))
    else $error("period flag with clear select high");

  a_ovf_no_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_COMPARE && s_r.ca == 16'h0000)
    |=> !$rose(s_r.flg[FLG_A]))
    else $error("compare A flag with zero compare value");

  a_timer_free: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode == MODE_TIMER |=> !s_r.oe)
    else $error("pin driven in timer mode");

  a_pwm_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && mode == MODE_PWM && !sp_mode && inc >= {1'h0, peff})
    |=> s_r.cnt == 16'h0000 && s_r.flg[FLG_P])
    else $error("pwm period wrap wrong");

  a_pwm_full: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_PWM && fn == FN_BOTH && s_r.ca >= peff)
    |=> s_r.pin == ($past(s_r.ctl[CTL_OIL]) ^ $past(s_r.ctl[CTL_INV])))
    else $error("pwm not at full duty");

  a_pwm_force: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_PWM && fn == FN_LOW)
    |=> s_r.pin == (!$past(s_r.ctl[CTL_OIL]) ^ $past(s_r.ctl[CTL_INV])))
    else $error("pwm forced level wrong");

  a_sp_trigger: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sp_mode && !s_r.run && ext_rise) |=> s_r.run && s_r.cnt == 16'h0000)
    else $error("clock pin did not start pulse");

  a_sp_end: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sp_mode && a_evt) |=> !s_r.run && s_r.flg[FLG_A])
    else $error("compare A did not end pulse");

  a_cap_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    cap_evt |=> s_r.ca == $past(s_r.cnt) && s_r.flg[FLG_A])
    else $error("capture did not copy counter");

  a_cap_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_CAPTURE && fn == FN_TOGGLE) |=> !$rose(s_r.flg[FLG_A]))
    else $error("capture while disabled");

  a_cmp_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    (a_evt && mode == MODE_COMPARE && fn == FN_BOTH) |=> s_r.lvl)
    else $error("compare A did not drive level high");

  a_cmp_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    (a_evt && mode == MODE_COMPARE && fn == FN_HIGH) |=> !s_r.lvl)
    else $error("compare A did not drive level low");

  a_pwm_active: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_PWM && fn == FN_HIGH)
    |=> s_r.pin == ($past(s_r.ctl[CTL_OIL]) ^ $past(s_r.ctl[CTL_INV])))
    else $error("pwm forced active level wrong");

  a_sp_no_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    sp_mode |=> !$rose(s_r.flg[FLG_P]))
    else $error("period flag in single pulse");

  a_cap_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && mode == MODE_CAPTURE && s_r.per != 16'h0000 &&
     inc[15:0] == s_r.per)
    |=> s_r.cnt == 16'h0000 && s_r.flg[FLG_P])
    else $error("capture period match did not wrap");

endmodule // periodic_timer

/* shared/timer_pkg.sv */
// Constants, register map and carrier types of the periodic timer.
// Assumes an APB master with byte addresses, 32-bit data and no strobes.
//
// Contract
// - Mode 00 is compare output; clears on overflow, compare A or period.
// - Clear select low: clear on period match or overflow; both flags.
// - Clear select high: clear on compare A match; never period flag.
// - Compare A zero: overflow at ffff, no compare A flag.
// - Compare mode pin moves only on A flag: low, high, toggle or hold.
// - Rising run enable loads the pin with the initial level.
// - Mode 11 acts as compare mode but leaves the pin undriven.
// - PWM: clear select ignored; period clears, A sets duty; both flag.
// - PWM duty value at or above period gives full duty.
// - PWM pin function 00/01 forces inactive/active; counting continues.
// - Initial level picks PWM active level; invert flips polarity.
// - Single pulse starts on run rise, by software or clock pin edge.
// - Single pulse ends on run clear, by software or A match with flag.
// - Single pulse: counter zeroed only on run rise; period unused.
// - Mode 01 captures from capture pin or clock pin by source select.
// - Capture edge copies counter into compare A and raises A flag.
// - Capture mode: free run, period match zeroes counter, period flag.
// - Capture function 11 blocks all captures; counter keeps running.
// - Capture edge: 00 rising, 01 falling, 10 both, 11 none.
// - Run rise zeroes the counter; run fall stops and holds it.
package timer_pkg;
  localparam logic [7:0] OFS_RUN = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_CA = 8'h0c;
  localparam logic [7:0] OFS_PER_LO = 8'h10;
  localparam logic [7:0] OFS_PER_HI = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam int RUN_BIT = 0;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_FN_LO = 4;
  localparam int CTL_OIL = 3;
  localparam int CTL_INV = 2;
  localparam int CTL_CSS = 1;
  localparam int CTL_CLR = 0;
  localparam int FLG_A = 0;
  localparam int FLG_P = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] FN_LOW = 2'h0;
  localparam logic [1:0] FN_HIGH = 2'h1;
  localparam logic [1:0] FN_BOTH = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } mode_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic ext_clk;
    logic cap_in;
  } pin_in_t;
  typedef struct packed {
    logic level;
    logic oe;
  } pin_out_t;
  typedef struct packed {
    logic run;
    logic [7:0] ctl;
    logic [15:0] cnt;
    logic [15:0] ca;
    logic [15:0] per;
    logic [1:0] flg;
    logic lvl;
    logic pin;
    logic oe;
    logic ext_q;
    logic cap_q;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } tmr_state_t;
endpackage

/* tb/periodic_timer_tb.sv */
// Self-checking bench of the periodic timer over APB and its pins.
// Assumes one pclk domain and a tick on every second pclk cycle.
`timescale 1ns/1ns
module periodic_timer_tb;
  import timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic tick_en = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  pin_in_t pin_i;
  pin_out_t pin_o;
  int miscompares = 0;
  int n_compared = 0;
  int k;
  logic [31:0] q;
  logic [31:0] q2;
  logic e;
  logic [7:0] cc [4] = '{8'h21, 8'h19, 8'h09, 8'he1};
  logic cq [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] pc [6] = '{8'ha9, 8'ha9, 8'h89, 8'h99, 8'ha1, 8'had};
  logic [15:0] pa [6] = '{16'h2, 16'h9, 16'h2, 16'h2, 16'h2, 16'h2};
  int ph [6] = '{32, 128, 0, 128, 96, 96};
  logic [31:0] pf [6] = '{32'h3, 32'h2, 32'h3, 32'h3, 32'h3, 32'h3};

  always #2 pclk = ~pclk;
  // Gapped ticks catch a counter that ignores the enable
  always @(posedge pclk) tick_en <= presetn & ~tick_en;

  periodic_timer u_periodic_timer (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .tick_en(tick_en), .pins_in(pin_i), .pins_out(pin_o));
  pin_partner u_pin_partner (.pclk(pclk), .pins_out(pin_o), .pins_in(pin_i));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    // Sample at the rising edge; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1);
    check("pready", rsp.pready, 32'h1);
    // Slave answers in the first access cycle
    check("wait states", n, 32'h1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [15:0] a,
                     input logic [15:0] p, input logic go);
    wr(OFS_RUN, 32'h0);
    wr(OFS_CTL, {24'h0, c});
    wr(OFS_CA, {16'h0, a});
    wr(OFS_PER_LO, {24'h0, p[7:0]});
    wr(OFS_PER_HI, {24'h0, p[15:8]});
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_RUN, {31'h0, go});
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTL);
    check("ctl reset", q, 32'h0);
    rd(OFS_PER_HI);
    check("per hi reset", q, 32'h0);
    wr(OFS_PER_HI, 32'ha5);
    rd(OFS_PER_HI);
    check("per hi rw", q, 32'ha5);
    rd(8'h1c);
    check("unmapped err", e, 32'h1);
    check("unmapped data", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg(cc[i], 16'h20, 16'h10, 1'b1);
      cyc(3);
      if (cc[i][7:6] != 2'b11)
        check("init lvl", pin_o.level, cc[i][3]);
      cyc(100);
      check("oe", pin_o.oe, cc[i][7:6] != 2'b11);
      if (cc[i][7:6] != 2'b11) check("match lvl", pin_o.level, cq[i]);
      rd(OFS_FLAGS);
      check("flags clr1", q, 32'h1);
      rd(OFS_CNT);
      check("cnt under a", q < 32'h20, 32'h1);
    end
    cfg(8'h31, 16'h20, 16'h10, 1'b1);
    u_pin_partner.count_high(128, k);
    check("toggle", k, 64);
    cfg(8'h20, 16'h8, 16'h10, 1'b1);
    cyc(100);
    rd(OFS_FLAGS);
    check("flags clr0", q, 32'h3);
    rd(OFS_CNT);
    check("cnt under p", q < 32'h10, 32'h1);
    cfg(8'h01, 16'h0, 16'h10, 1'b1);
    cyc(100);
    rd(OFS_FLAGS);
    check("flags a zero", q, 32'h0);
    rd(OFS_CNT);
    check("cnt no clear", q > 32'h20, 32'h1);
    for (int i = 0; i < 6; i++) begin
      cfg(pc[i], pa[i], 16'h8, 1'b1);
      cyc(40);
      u_pin_partner.count_high(128, k);
      check("pwm high", k, ph[i]);
      rd(OFS_FLAGS);
      check("pwm flags", q, pf[i]);
    end
    // Single pulse set up stopped, so the pin edge starts it
    u_pin_partner.drive(1'b0, 1'b0);
    cfg(8'hb8, 16'h10, 16'h0, 1'b0);
    u_pin_partner.drive(1'b1, 1'b0);
    u_pin_partner.count_high(80, k);
    check("pulse width", k >= 28 && k <= 36, 32'h1);
    rd(OFS_RUN);
    check("run auto clr", q, 32'h0);
    rd(OFS_FLAGS);
    check("pulse flag", q[FLG_A], 32'h1);
    u_pin_partner.drive(1'b0, 1'b0);
    wr(OFS_RUN, 32'h1);
    cyc(2);
    check("sw lead", pin_o.level, 32'h1);
    rd(OFS_CNT);
    check("restart cnt", q < 32'h8, 32'h1);
    wr(OFS_RUN, 32'h0);
    cyc(2);
    check("sw trail", pin_o.level, 32'h0);
    for (int s = 0; s < 2; s++) begin
      for (int f = 0; f < 4; f++) begin
        u_pin_partner.drive(!s[0], s[0]);
        cfg({2'b01, f[1:0], 2'b00, s[0], 1'b0}, 16'h0, 16'h20, 1'b1);
        u_pin_partner.drive(1'b0, 1'b0);
        cyc(40);
        u_pin_partner.drive(s[0], !s[0]);
        cyc(60);
        rd(OFS_FLAGS);
        check("cap rise", q,
              {30'h0, 1'b1, f == 0 || f == 2});
        rd(OFS_CA);
        check("captured", q != 0 && q < 32'h20,
              f == 0 || f == 2);
        wr(OFS_FLAGS, 32'h3);
        u_pin_partner.drive(1'b0, 1'b0);
        cyc(20);
        rd(OFS_FLAGS);
        check("cap fall", q[FLG_A], f == 1 || f == 2);
      end
    end
    wr(OFS_RUN, 32'h0);
    rd(OFS_CNT);
    q2 = q;
    cyc(20);
    rd(OFS_CNT);
    check("cnt held", q, q2);
    end_sim();
  end
endmodule // periodic_timer_tb

/* tb/pin_partner.sv */
// Model of the pins around the timer: clock and capture inputs, output pin.
// Assumes pins_in is sampled on pclk and pins_out is registered.
`timescale 1ns/1ns
module pin_partner
  import timer_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Pins
  input wire timer_pkg::pin_out_t pins_out,
  output timer_pkg::pin_in_t pins_in
);
  initial pins_in = '0;

  // Both input lines are driven at all times, so no floating level
  task automatic drive(input logic e, input logic c);
    @(posedge pclk);
    pins_in <= '{ext_clk: e, cap_in: c};
  endtask

  // Undriven pin counts as low
  task automatic count_high(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge pclk);
      if (pins_out.level === 1'b1 && pins_out.oe === 1'b1) k++;
    end
  endtask
endmodule // pin_partner
